// ### dv/osdt_core_tb_top.sv
`timescale 1ns/1ps
`include "osdt_defines.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module osdt_core_tb_top;
  import osdt_pkg::*;
  logic        core_clk, rst_n, vs, hs, bv, bf, br, gm, ro, go, bo, fb, fosc;
  logic [7:0]  bd, gc, code0;
  logic [4:0]  gl;
  logic [1:0]  prs;
  logic [10:0] pmul;
  logic [12:0] e;
  logic [12:0] exp_q[$];
  osdt_parse_e pst;
  logic        mon_on = 1'b0;
  logic        sync_on = 1'b0;
  int          n_mismatch = 0, n_tests = 0, line_no = 0, dot = 0, ln = 0;

  // rom stand-in: multicolour glyphs light their leftmost red dot
  osdt_core dut (.CORE_CLK(core_clk), .RST_N(rst_n), .CE(1'b1),
    .VERTICAL_SYNC_IN(vs), .HORIZONTAL_SYNC_IN(hs), .BYTE_VALID(bv),
    .BYTE_FIRST(bf), .BYTE_DATA(bd), .BYTE_READY(br), .GLYPH_CODE(gc),
    .GLYPH_LINE(gl), .GLYPH_MULTI(gm), .GLYPH_R_BITS({gm, 11'h000}),
    .GLYPH_G_BITS(12'h000), .GLYPH_B_BITS(12'h000), .RED_OUT(ro),
    .GREEN_OUT(go), .BLUE_OUT(bo), .FAST_BLANK_OUT(fb),
    .PLL_RANGE_SELECT(prs), .PLL_MULTIPLIER(pmul), .FALLBACK_OSC(fosc),
    .PARSE_STATE(pst));
  osdt_host_model host (.clk(core_clk), .byte_ready(br), .byte_valid(bv),
    .byte_first(bf), .byte_data(bd));

  // 40 mhz core clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // hsync every 480 dots, vsync every 40 lines
  always @(posedge core_clk) begin
    if (sync_on) begin
      #2;
      dot = (dot == 479) ? 0 : dot + 1;
      hs = (dot < 8);
      if (dot == 0) begin
        ln = (ln == 39) ? 0 : ln + 1;
        line_no++;
      end
      if (dot == 100) begin
        vs = (ln < 2);
        if (ln == 0) line_no = 0;
      end
    end
  end
  // compare pll outputs with oldest note
  always @(prs or pmul) begin
    if (mon_on) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 13'bx;
      `CHK({prs, pmul}, e)
    end
  end
  // watchdog
  initial begin
    repeat (90000) @(posedge core_clk);
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    close_out();
  end

  task automatic close_out();
    $display("counts: tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [4:0] col, input logic [7:0] d);
    host.send(1'b1, host.row_b(1'b0, 4'd15));
    host.send(1'b0, {3'b000, col});
    host.send(1'b0, d);
  endtask
  task automatic chk_st(input osdt_parse_e s);
    int k;
    k = 0;
    while (pst !== s && k < 800) begin
      @(posedge core_clk);
      k++;
    end
    `CHK(pst, s)
  endtask
  // stream a whole plane: cell 0,0 gets code0 or background 101
  task automatic fill(input logic attr);
    host.send(1'b1, host.row_b(attr, 4'd0));
    chk_st(OSDT_P_COL);
    host.send(1'b0, 8'h40);
    chk_st(OSDT_P_DATA);
    for (int i = 0; i < 480; i++) host.send(1'b0, (i == 0) ? (attr ? 8'h50 : code0) : 8'h00);
    chk_st(OSDT_P_STREAM);
  endtask

  // main sequence
  initial begin
    logic [6:0] res;
    int hst, vst, lcap, dcap, w, k;
    rst_n = 1'b0;
    hs = 1'b0;
    vs = 1'b0;
    void'($urandom(40665));
    code0 = 8'(224 + $urandom % 32);
    repeat (10) @(posedge core_clk);
    #2 rst_n = 1'b1;
    @(posedge core_clk);
    `CHK(br, 1'b1)
    `CHK(pmul, 11'd480)
    `CHK(prs, 2'b00)
    `CHK(pst, OSDT_P_ROW)
    `CHK(fb, 1'b0)
    $display("test reset done");
    mon_on = 1'b1;
    repeat (4010) @(posedge core_clk);
    `CHK(fosc, 1'b1)
    sync_on = 1'b1;
    repeat (1000) @(posedge core_clk);
    `CHK(fosc, 1'b0)
    $display("test fallback done");
    fill(1'b0);
    fill(1'b1);
    $display("test stream done");
    for (int c = 1; c < 5; c++) begin
      exp_q.push_back({c[1:0], 11'd480});
      wr(`OSDT_COL_PLLCFG, {6'd0, c[1:0]});
    end
    res = 7'(36 + $urandom % 59);
    if (res == 7'd40) res = 7'd41;
    exp_q.push_back({2'b00, 11'(res) * 11'd12});
    wr(`OSDT_COL_HRES, {1'b0, res});
    exp_q.push_back({2'b00, 11'd480});
    wr(`OSDT_COL_HRES, 8'd40);
    wr(`OSDT_COL_FONTSEL, 8'h01);
    repeat (800) @(posedge core_clk);
    `CHK(exp_q.size(), 0)
    $display("test registers done");
    hst = $urandom % 12;
    vst = $urandom % 5;
    wr(`OSDT_COL_HSTART, 8'(hst));
    wr(`OSDT_COL_VSTART, 8'(vst));
    repeat (500) @(posedge core_clk);
    @(posedge vs);
    k = 0;
    while (fb !== 1'b1 && k < 40000) begin
      @(negedge core_clk);
      k++;
    end
    lcap = line_no;
    dcap = dot;
    `CHK({ro, go, bo}, (code0 >= `OSDT_MULTI_FIRST) ? 3'b100 : 3'b101)
    `CHK(gm, code0 >= `OSDT_MULTI_FIRST)
    `CHK(gc, code0)
    `CHK(gl, 5'd0)
    @(negedge core_clk);
    `CHK({ro, go, bo}, 3'b101)
    w = 1;
    while (fb === 1'b1 && w < 40) begin
      @(negedge core_clk);
      w++;
    end
    `CHK(w, 12)
    `CHK(lcap == vst * 4 + 1 || lcap == vst * 4 + 2, 1'b1)
    `CHK(dcap >= hst * 6 + 49 && dcap <= hst * 6 + 57, 1'b1)
    $display("test timing done");
    close_out();
  end
endmodule

// ### dv/osdt_host_model.sv
`timescale 1ns/1ps
// host side: offers serial bytes and holds each until taken
module osdt_host_model (
  input  wire logic       clk,        // core clock
  input  wire logic       byte_ready, // core has room
  output logic            byte_valid, // byte offered
  output logic            byte_first, // transfer start
  output logic [7:0]      byte_data   // byte value
);
  // idle values from time zero
  initial begin
    byte_valid = 1'b0;
    byte_first = 1'b0;
    byte_data  = 8'h00;
  end
  // one byte, random stall first; released data is inverted
  // first flag only opens a transfer
  task automatic send(input logic first, input logic [7:0] d);
    int gap;
    gap = 1 + $urandom % 3;
    repeat (gap) @(posedge clk);
    #2;
    byte_valid = 1'b1;
    byte_first = first;
    byte_data  = d;
    @(posedge clk);
    while (byte_ready !== 1'b1) @(posedge clk);
    #2;
    byte_valid = 1'b0;
    byte_first = 1'b0;
    byte_data  = ~d;
  endtask
  function automatic logic [7:0] row_b(input logic attr, input logic [3:0] r);
    return {2'b10, attr, 1'b0, r};
  endfunction
endmodule

// ### logic/osdt_core.sv
`timescale 1ns/1ps
`include "osdt_defines.svh"
module osdt_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,       // core clock
  input  wire logic             rst_n,     // sync reset
  input  wire logic             ce,        // clock enable
  input  wire logic             in_valid,  // write request
  output logic                  in_ready,  // space left
  input  wire logic [WIDTH-1:0] in_data,   // write word
  output logic                  out_valid, // word present
  input  wire logic             out_ready, // drain request
  output logic      [WIDTH-1:0] out_data   // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW:0]      wptr_ff;
  logic [AW:0]      rptr_ff;
  logic             push;
  logic             pop;

  // full and empty from pointer wrap bit
  assign in_ready  = (wptr_ff[AW] == rptr_ff[AW]) || (wptr_ff[AW-1:0] != rptr_ff[AW-1:0]);
  assign out_valid = (wptr_ff != rptr_ff);
  assign push      = ce & in_valid & in_ready;
  assign pop       = ce & out_valid & out_ready;
  assign out_data  = mem[rptr_ff[AW-1:0]];

  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr_ff[AW-1:0]] <= in_data;
    end
  end

  // pointers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
    end else begin
      if (push) begin
        wptr_ff <= wptr_ff + 1'b1;
      end
      if (pop) begin
        rptr_ff <= rptr_ff + 1'b1;
      end
    end
  end
endmodule

module osdt_core #(
  parameter logic [10:0] PHASE_PULSE_DOTS = 11'd0
) (
  input  wire logic                 CORE_CLK,           // dot clock
  input  wire logic                 RST_N,              // sync reset, active low
  input  wire logic                 CE,                 // clock enable
  input  wire logic                 VERTICAL_SYNC_IN,   // vsync pin
  input  wire logic                 HORIZONTAL_SYNC_IN, // hsync pin
  input  wire logic                 BYTE_VALID,         // serial byte offered
  input  wire logic                 BYTE_FIRST,         // first byte of transfer
  input  wire logic [7:0]           BYTE_DATA,          // serial byte
  output logic                      BYTE_READY,         // fifo has room
  output logic [7:0]                GLYPH_CODE,         // rom character
  output logic [4:0]                GLYPH_LINE,         // rom glyph line
  output logic                      GLYPH_MULTI,        // rom multicolour bank
  input  wire logic [11:0]          GLYPH_R_BITS,       // rom red / mono plane
  input  wire logic [11:0]          GLYPH_G_BITS,       // rom green plane
  input  wire logic [11:0]          GLYPH_B_BITS,       // rom blue plane
  output logic                      RED_OUT,            // red dot
  output logic                      GREEN_OUT,          // green dot
  output logic                      BLUE_OUT,           // blue dot
  output logic                      FAST_BLANK_OUT,     // osd drawing
  output logic [1:0]                PLL_RANGE_SELECT,   // vco band
  output logic [10:0]               PLL_MULTIPLIER,     // dots per line
  output logic                      FALLBACK_OSC,       // hsync absent
  output osdt_pkg::osdt_parse_e     PARSE_STATE         // byte parser state
);
  import osdt_pkg::*;

  logic [2:0]  vs_sync_ff, hs_sync_ff;
  logic        vs_lvl_ff, hs_lvl_ff, v_edge, h_edge;
  logic [12:0] hloss_ff;
  logic [7:0]  code_mem [0:511];
  logic [6:0]  attr_mem [0:511];
  logic [1:0]  rowctl_ff [0:15];   // entry 15 stays zero for the row after the window
  logic [7:0]  vstart_ff, hstart_ff;
  logic [6:0]  cheight_ff, hres_ff;
  logic [1:0]  pll_ff;
  logic        colour_font_select_ff;
  logic [8:0]  f_data;
  logic        f_valid, drain_ok, pop;
  osdt_parse_e state_ff;
  logic [3:0]  wrow_ff;
  logic [4:0]  wcol_ff;
  logic        wattr_ff, fmt_c_ff;
  logic        wr_now, we_cell;
  logic [10:0] hdelay, hcnt_ff;
  logic        hpend_ff, h_act_ff;
  logic [8:0]  dot_ff;
  logic [4:0]  col_ff, sub_ff;
  logic [9:0]  vdelay, vline_ff;
  logic        vdly_ff, v_act_ff;
  logic [3:0]  row_ff, rep_ff, copies;
  logic [4:0]  gline_ff;
  logic [4:0]  frame_ff;
  logic        blink_ph_ff;
  logic [6:0]  attr1_ff;
  logic [3:0]  sub1_ff;
  logic        vis1_ff;
  logic [3:0]  bidx;
  logic        pr, pg, pb, fg_on, bg_on;

  // pin synchronisers: change counts once stages 2 and 3 agree
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      vs_sync_ff <= 3'h0;
      hs_sync_ff <= 3'h0;
      vs_lvl_ff  <= 1'b0;
      hs_lvl_ff  <= 1'b0;
    end else if (CE) begin
      vs_sync_ff <= {vs_sync_ff[1:0], VERTICAL_SYNC_IN};
      hs_sync_ff <= {hs_sync_ff[1:0], HORIZONTAL_SYNC_IN};
      if (vs_sync_ff[1] == vs_sync_ff[2]) vs_lvl_ff <= vs_sync_ff[2];
      if (hs_sync_ff[1] == hs_sync_ff[2]) hs_lvl_ff <= hs_sync_ff[2];
    end
  end
  assign v_edge = CE & (vs_sync_ff[1] == vs_sync_ff[2]) & vs_sync_ff[2] & ~vs_lvl_ff;
  assign h_edge = CE & (hs_sync_ff[1] == hs_sync_ff[2]) & hs_sync_ff[2] & ~hs_lvl_ff;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      hloss_ff <= 13'h0000;
    end else if (CE) begin
      if (h_edge) hloss_ff <= 13'h0000;
      else if (hloss_ff != 13'(`OSDT_HLOSS_CYC)) hloss_ff <= hloss_ff + 13'h0001;
    end
  end
  assign FALLBACK_OSC = (hloss_ff == 13'(`OSDT_HLOSS_CYC));

  assign PLL_RANGE_SELECT = pll_ff;
  assign PLL_MULTIPLIER   = 11'(hres_ff) * 11'(`OSDT_CELL_DOTS);

  // write buffer between serial front end and display ram
  osdt_fifo #(.WIDTH(9), .DEPTH(8)) u_fifo (
    .clk      (CORE_CLK),
    .rst_n    (RST_N),
    .ce       (CE),
    .in_valid (BYTE_VALID),
    .in_ready (BYTE_READY),
    .in_data  ({BYTE_FIRST, BYTE_DATA}),
    .out_valid(f_valid),
    .out_ready(drain_ok),
    .out_data (f_data)
  );
  // drain only while the display is not fetching
  assign drain_ok = ~(h_act_ff & v_act_ff);
  assign pop      = CE & f_valid & drain_ok;
  assign wr_now   = pop & ~f_data[8] & ((state_ff == OSDT_P_DATA) || (state_ff == OSDT_P_STREAM));
  // cells only in rows 0-14 columns 0-29
  assign we_cell  = wr_now & (wrow_ff < `OSDT_ROWS) & (wcol_ff < `OSDT_COLS);
  assign PARSE_STATE = state_ff;

  // row / column / data parser
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      state_ff <= OSDT_P_ROW;
      wrow_ff  <= 4'h0;
      wcol_ff  <= 5'h00;
      wattr_ff <= 1'b0;
      fmt_c_ff <= 1'b0;
    end else if (pop) begin
      if (f_data[8] || state_ff == OSDT_P_ROW || state_ff == OSDT_P_COL) begin
        if (f_data[7]) begin
          // bit 5 of row byte picks attribute plane
          wrow_ff  <= f_data[3:0];
          wattr_ff <= f_data[5];
          state_ff <= OSDT_P_COL;
        end else if (!f_data[8] && state_ff == OSDT_P_COL) begin
          wcol_ff  <= f_data[4:0];
          fmt_c_ff <= f_data[6];
          state_ff <= OSDT_P_DATA;
        end
      end else begin
        if (fmt_c_ff) begin
          wcol_ff <= wcol_ff + 5'h01;
          if (wcol_ff == 5'h1F) wrow_ff <= wrow_ff + 4'h1;
        end
        // streaming state is never left inside a transfer
        state_ff <= fmt_c_ff ? OSDT_P_STREAM : OSDT_P_COL;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (we_cell && !wattr_ff) code_mem[{wrow_ff, wcol_ff}] <= f_data[7:0];
    if (we_cell && wattr_ff) attr_mem[{wrow_ff, wcol_ff}] <= f_data[6:0];
  end

  // row control and frame control bytes
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      for (int i = 0; i < 16; i++) rowctl_ff[i] <= 2'b00;
      vstart_ff  <= `OSDT_RST_VSTART;
      hstart_ff  <= `OSDT_RST_HSTART;
      cheight_ff <= 7'h00;
      hres_ff    <= `OSDT_RST_HRES;
      pll_ff     <= 2'b00;
      colour_font_select_ff   <= 1'b0;
    end else if (wr_now && !wattr_ff) begin
      if (wrow_ff < `OSDT_ROWS && wcol_ff == `OSDT_COL_ROWCTRL) begin
        rowctl_ff[wrow_ff] <= f_data[1:0];
      end
      if (wrow_ff == `OSDT_CTRL_ROW) begin
        unique case (wcol_ff)
          `OSDT_COL_VSTART:  vstart_ff  <= f_data[7:0];
          `OSDT_COL_HSTART:  hstart_ff  <= f_data[7:0];
          `OSDT_COL_CHEIGHT: cheight_ff <= f_data[6:0];
          `OSDT_COL_HRES:    hres_ff    <= f_data[6:0];
          `OSDT_COL_PLLCFG:  pll_ff     <= f_data[1:0];
          `OSDT_COL_FONTSEL: colour_font_select_ff   <= f_data[0];
          default:           colour_font_select_ff   <= colour_font_select_ff;
        endcase
      end
    end
  end

  assign hdelay = (11'(hstart_ff) * `OSDT_HSTEP) + `OSDT_HOFFSET - PHASE_PULSE_DOTS;

  // horizontal position and cell counters
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      hcnt_ff  <= 11'h000;
      hpend_ff <= 1'b0;
      h_act_ff <= 1'b0;
      dot_ff   <= 9'h000;
      col_ff   <= 5'h00;
      sub_ff   <= 5'h00;
    end else if (CE) begin
      if (h_edge) begin
        hcnt_ff  <= 11'h000;
        hpend_ff <= 1'b1;
        h_act_ff <= 1'b0;
      end else if (hpend_ff) begin
        hcnt_ff <= hcnt_ff + 11'h001;
        if (hcnt_ff + 11'h001 >= hdelay) begin
          hpend_ff <= 1'b0;
          h_act_ff <= 1'b1;
          dot_ff   <= 9'h000;
          col_ff   <= 5'h00;
          sub_ff   <= 5'h00;
        end
      end else if (h_act_ff) begin
        dot_ff <= dot_ff + 9'h001;
        if (dot_ff == `OSDT_ACTIVE_DOTS - 9'h001) h_act_ff <= 1'b0;
        // double width: 24-dot cells, even columns only
        if (sub_ff == (rowctl_ff[row_ff][0] ? 5'd23 : 5'd11)) begin
          sub_ff <= 5'h00;
          col_ff <= col_ff + (rowctl_ff[row_ff][0] ? 5'h02 : 5'h01);
        end else begin
          sub_ff <= sub_ff + 5'h01;
        end
      end
    end
  end

  // scan lines spent on one glyph line
  function automatic logic [3:0] copies_f(input logic [4:0] ln, input logic [6:0] ch,
                                          input logic dh);
    logic [3:0] c;
    logic [4:0] lo;
    c  = (ch[6:5] == 2'b11) ? 4'h3 : (ch[6] ? 4'h2 : 4'h1);
    lo = ch[4:0];
    if (lo >= `OSDT_LO_CLAMP) begin
      c = c + {3'h0, (ln <= 5'd16)};
    end else begin
      c = c + {3'h0, lo[4] & (ln >= 5'd1) & (ln <= 5'd16)};
      c = c + {3'h0, lo[3] & ln[0] & (ln <= 5'd15)};
      c = c + {3'h0, lo[2] & (ln[1:0] == 2'b10) & (ln <= 5'd14)};
      c = c + {3'h0, lo[1] & (ln[2:0] == 3'b100) & (ln <= 5'd12)};
      c = c + {3'h0, lo[0] & (ln == 5'd8)};
    end
    return dh ? {c[2:0], 1'b0} : c;
  endfunction
  assign copies = copies_f(gline_ff, cheight_ff, rowctl_ff[row_ff][1]);
  assign vdelay = ({2'b00, vstart_ff} << `OSDT_VSTEP) + 10'h001;

  // vertical window: delay, then 15 rows of repeated glyph lines
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      vline_ff <= 10'h000;
      vdly_ff  <= 1'b0;
      v_act_ff <= 1'b0;
      row_ff   <= 4'h0;
      gline_ff <= 5'h00;
      rep_ff   <= 4'h0;
    end else if (v_edge) begin
      vline_ff <= 10'h000;
      vdly_ff  <= 1'b1;
      v_act_ff <= 1'b0;
    end else if (h_edge && vdly_ff) begin
      vline_ff <= vline_ff + 10'h001;
      if (vline_ff + 10'h001 == vdelay) begin
        vdly_ff  <= 1'b0;
        v_act_ff <= 1'b1;
        row_ff   <= 4'h0;
        gline_ff <= 5'h00;
        rep_ff   <= 4'h0;
      end
    end else if (h_edge && v_act_ff) begin
      if (rep_ff + 4'h1 >= copies) begin
        rep_ff <= 4'h0;
        if (gline_ff == `OSDT_GLYPH_LINES - 5'h01) begin
          gline_ff <= 5'h00;
          row_ff   <= row_ff + 4'h1;
          if (row_ff == `OSDT_ROWS - 4'h1) v_act_ff <= 1'b0;
        end else begin
          gline_ff <= gline_ff + 5'h01;
        end
      end else begin
        rep_ff <= rep_ff + 4'h1;
      end
    end
  end

  // blink phase flips every 32 frames
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      frame_ff    <= 5'h00;
      blink_ph_ff <= 1'b0;
    end else if (v_edge) begin
      frame_ff <= frame_ff + 5'h01;
      if (frame_ff == `OSDT_BLINK_LAST) blink_ph_ff <= ~blink_ph_ff;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      GLYPH_CODE  <= 8'h00;
      GLYPH_LINE  <= 5'h00;
      GLYPH_MULTI <= 1'b0;
      attr1_ff    <= 7'h00;
      sub1_ff     <= 4'h0;
      vis1_ff     <= 1'b0;
    end else if (CE) begin
      GLYPH_CODE  <= code_mem[{row_ff, col_ff}];
      GLYPH_LINE  <= gline_ff;
      GLYPH_MULTI <= colour_font_select_ff & (code_mem[{row_ff, col_ff}] >= `OSDT_MULTI_FIRST);
      attr1_ff    <= attr_mem[{row_ff, col_ff}];
      sub1_ff     <= rowctl_ff[row_ff][0] ? sub_ff[4:1] : sub_ff[3:0];
      vis1_ff     <= h_act_ff & v_act_ff & (col_ff < `OSDT_COLS);
    end
  end

  // plane selection: multicolour planes or mono pattern times colour
  assign bidx  = 4'hB - sub1_ff;
  assign pr    = GLYPH_MULTI ? GLYPH_R_BITS[bidx] : GLYPH_R_BITS[bidx] & attr1_ff[2];
  assign pg    = GLYPH_MULTI ? GLYPH_G_BITS[bidx] : GLYPH_R_BITS[bidx] & attr1_ff[1];
  assign pb    = GLYPH_MULTI ? GLYPH_B_BITS[bidx] : GLYPH_R_BITS[bidx] & attr1_ff[0];
  assign fg_on = GLYPH_R_BITS[bidx] | (GLYPH_MULTI & (GLYPH_G_BITS[bidx] | GLYPH_B_BITS[bidx]));
  assign bg_on = (attr1_ff[6:4] != 3'b000);

  // dot output, dark outside the active window
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      {RED_OUT, GREEN_OUT, BLUE_OUT, FAST_BLANK_OUT} <= 4'h0;
    end else if (CE) begin
      if (vis1_ff && fg_on && !(attr1_ff[3] && blink_ph_ff)) begin
        {RED_OUT, GREEN_OUT, BLUE_OUT, FAST_BLANK_OUT} <= {pr, pg, pb, 1'b1};
      end else if (vis1_ff && bg_on) begin
        {RED_OUT, GREEN_OUT, BLUE_OUT, FAST_BLANK_OUT} <= {attr1_ff[6:4], 1'b1};
      end else begin
        {RED_OUT, GREEN_OUT, BLUE_OUT, FAST_BLANK_OUT} <= 4'h0;
      end
    end
  end

  property p_wr_outside;
    @(posedge CORE_CLK) disable iff (!RST_N) wr_now |-> !(h_act_ff && v_act_ff);
  endproperty
  a_wr_outside: assert property (p_wr_outside) else $error("write during fetch");
  property p_stream_inc;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (wr_now && fmt_c_ff && !f_data[8]) |=> wcol_ff == $past(wcol_ff) + 5'h01;
  endproperty
  a_stream_inc: assert property (p_stream_inc) else $error("no auto increment");
  property p_vdelay;
    @(posedge CORE_CLK) disable iff (!RST_N) $rose(v_act_ff) |-> vline_ff == vdelay;
  endproperty
  a_vdelay: assert property (p_vdelay) else $error("vertical delay wrong");
  property p_hdelay;
    @(posedge CORE_CLK) disable iff (!RST_N)
      $rose(h_act_ff) |-> $past(hcnt_ff) + 11'h001 >= hdelay;
  endproperty
  a_hdelay: assert property (p_hdelay) else $error("horizontal delay wrong");
  property p_hlen;
    @(posedge CORE_CLK) disable iff (!RST_N)
      $fell(h_act_ff) && !$past(h_edge) |-> $past(dot_ff) == 9'd359;
  endproperty
  a_hlen: assert property (p_hlen) else $error("active line not 360 dots");
  property p_dw_even;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (h_act_ff && rowctl_ff[row_ff][0]) |-> !col_ff[0];
  endproperty
  a_dw_even: assert property (p_dw_even) else $error("odd column shown");
  property p_copies;
    @(posedge CORE_CLK) disable iff (!RST_N)
      copies >= (rowctl_ff[row_ff][1] ? 4'h2 : 4'h1);
  endproperty
  a_copies: assert property (p_copies) else $error("glyph line dropped");
  property p_reserved;
    @(posedge CORE_CLK) disable iff (!RST_N) we_cell |-> wcol_ff < 5'd30;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved column written");
  property p_blink;
    @(posedge CORE_CLK) disable iff (!RST_N)
      $changed(blink_ph_ff) |-> $past(v_edge) && $past(frame_ff) == 5'h1F;
  endproperty
  a_blink: assert property (p_blink) else $error("blink phase off");
  property p_blank;
    @(posedge CORE_CLK) disable iff (!RST_N) CE && !vis1_ff |=> !FAST_BLANK_OUT;
  endproperty
  a_blank: assert property (p_blank) else $error("dots in blank region");
  c_stream: cover property (@(posedge CORE_CLK) state_ff == OSDT_P_STREAM && wr_now);
  c_display: cover property (@(posedge CORE_CLK) FAST_BLANK_OUT);
  c_fallback: cover property (@(posedge CORE_CLK) $rose(FALLBACK_OSC));
endmodule

// ### pkg/osdt_defines.svh
`ifndef OSDT_DEFINES_SVH
`define OSDT_DEFINES_SVH
// screen geometry
`define OSDT_ROWS          4'd15
`define OSDT_COLS          5'd30
`define OSDT_COL_ROWCTRL   5'd30
`define OSDT_COL_RESERVED  5'd31
`define OSDT_CTRL_ROW      4'd15
`define OSDT_CELL_DOTS     5'd12
`define OSDT_ACTIVE_DOTS   9'd360
`define OSDT_GLYPH_LINES   5'd18
`define OSDT_LO_CLAMP      5'd17
// control bytes held in row 15
`define OSDT_COL_VSTART    5'd12
`define OSDT_COL_HSTART    5'd13
`define OSDT_COL_CHEIGHT   5'd14
`define OSDT_COL_HRES      5'd15
`define OSDT_COL_PLLCFG    5'd18
`define OSDT_COL_FONTSEL   5'd19
// reset values
`define OSDT_RST_VSTART    8'h04
`define OSDT_RST_HSTART    8'h0F
`define OSDT_RST_HRES      7'h28
// timing arithmetic
`define OSDT_VSTEP         2
`define OSDT_HSTEP         11'd6
`define OSDT_HOFFSET       11'd49
`define OSDT_BLINK_LAST    5'h1F
`define OSDT_MULTI_FIRST   8'hF0
// hsync loss detection
`define OSDT_CLK_MHZ       40
`define OSDT_HLOSS_US      100
`define OSDT_HLOSS_CYC     (`OSDT_HLOSS_US * `OSDT_CLK_MHZ)
`endif

// ### pkg/osdt_pkg.sv
package osdt_pkg;
  // serial byte parser states
  typedef enum logic [1:0] {
    OSDT_P_ROW    = 2'b00,
    OSDT_P_COL    = 2'b01,
    OSDT_P_DATA   = 2'b10,
    OSDT_P_STREAM = 2'b11
  } osdt_parse_e;
endpackage
